// file: logic/htc_pkg.sv
/*
  Package for the host transfer control block: register offsets, control bit
  positions, reset values and the carrier structs shared by the block.
  Assumes a 10-bit host I/O address and an 8-bit host register data path.
*/
package htc_pkg;
	// Host I/O offsets of the registers and data port aliases.
	localparam logic [9:0] HTC_CTRL_ADDR = 10'h352;
	localparam logic [9:0] HTC_COUNT_ADDR = 10'h355;
	localparam logic [9:0] HTC_DATA_ADDR = 10'h356;
	localparam logic [9:0] HTC_DATA_ALIAS_ADDR = 10'h358;
	// Control register bit positions.
	localparam int HTC_BIT_ENABLE = 7;
	localparam int HTC_BIT_NARROW = 6;
	localparam int HTC_BIT_DMA = 5;
	localparam int HTC_BIT_QUAD = 4;
	localparam int HTC_BIT_DIR = 3;
	localparam int HTC_BIT_GATE = 2;
	localparam int HTC_BIT_CLEAR = 1;
	localparam int HTC_BIT_SOFT = 0;
	// Reset values.
	localparam logic [7:0] HTC_CTRL_RESET = 8'h00;
	localparam logic [7:0] HTC_COUNT_RESET = 8'h00;
	// Bytes moved per narrow and wide transfer.
	localparam logic [7:0] HTC_NARROW_BYTES = 8'h01;
	localparam logic [7:0] HTC_WIDE_BYTES = 8'h02;
	// Default depth of the host buffer in bytes.
	localparam int HTC_DEPTH = 128;

	// Host bus pin levels, carried through the synchroniser together.
	typedef struct packed {
		logic write;
		logic read;
		logic ack;
		logic last;
		logic [9:0] addr;
		logic [7:0] wdata;
	} htc_pins_s;

	// One counted transfer, reported to the buffer logic.
	typedef struct packed {
		logic pulse;
		logic to_buffer;
		logic wide;
	} htc_xfer_s;

	// Complete state of the block.
	typedef struct packed {
		htc_pins_s stage1;
		htc_pins_s stage2;
		htc_pins_s prev;
		logic [7:0] ctrl;
		logic [7:0] count;
		logic done;
		logic irq;
		logic drq;
		logic pio_ready;
		logic quad_port;
		logic [7:0] rdata;
		htc_xfer_s xfer;
	} htc_state_s;
endpackage : htc_pkg

// file: logic/htc_host_transfer_control.sv
/*
  Host transfer control: the control register, host buffer byte count,
  DMA request and programmed I/O handshake, done flag and interrupt pin.
  Assumes host strobes, address and data arrive as pins from the host bus and
  that the other interrupt sources come from logic on the same clock.
*/
`timescale 1ns/1ps
module htc_host_transfer_control
	import htc_pkg::*;
#(
	parameter int DEPTH = HTC_DEPTH
)(
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Host register and data port pins.
	input wire logic host_write,
	input wire logic host_read,
	input wire logic [9:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	// Host DMA handshake pins.
	input wire logic dma_ack,
	input wire logic dma_last,
	output logic dma_request,
	// Programmed I/O word ready and port emulation flag.
	output logic pio_ready,
	output logic quad_port,
	// Interrupt sources and pin.
	input wire logic event_irq,
	output logic irq,
	// Status toward the buffer logic.
	output logic host_side_done,
	output logic [7:0] buffer_byte_count,
	output htc_xfer_s xfer
);
	// The count is eight bits and the widest transfer is two bytes.
	if (DEPTH < 2 || DEPTH > 255)
	begin : g_depth_check
		$error("DEPTH must lie between 2 and 255");
	end

	localparam logic [7:0] DEPTH_BYTES = 8'(DEPTH);

	htc_state_s s; // Registered state.
	htc_state_s next_s; // Next state.
	logic write_edge; // Host write strobe just rose.
	logic read_edge; // Host read strobe just rose.
	logic ack_edge; // DMA acknowledge just rose.
	logic data_hit; // Access addresses the data port.
	logic [7:0] width; // Bytes per transfer.
	logic [7:0] room_width; // Bytes per transfer under the next control byte.
	logic room; // Buffer can take or give one transfer.
	logic moved; // A transfer is counted this cycle.

	// Compute every next value from the present state and synchronised pins.
	always_comb
	begin
		next_s = s;
		next_s.stage1 = '{host_write, host_read, dma_ack, dma_last, host_addr, host_wdata};
		next_s.stage2 = s.stage1;
		next_s.prev = s.stage2;
		write_edge = s.stage2.write && !s.prev.write;
		read_edge = s.stage2.read && !s.prev.read;
		ack_edge = s.stage2.ack && !s.prev.ack;
		data_hit = s.stage2.addr == HTC_DATA_ADDR
			|| (s.ctrl[HTC_BIT_QUAD] && s.stage2.addr == HTC_DATA_ALIAS_ADDR);
		width = s.ctrl[HTC_BIT_NARROW] ? HTC_NARROW_BYTES : HTC_WIDE_BYTES;
		moved = 1'b0;
		// A DMA transfer counts on each acknowledge while requesting.
		if (ack_edge && s.drq)
		begin
			moved = 1'b1;
		end
		// A programmed I/O transfer counts on a data port strobe when ready.
		else if ((write_edge || read_edge) && data_hit && s.pio_ready)
		begin
			moved = 1'b1;
		end
		next_s.xfer = '{moved, s.ctrl[HTC_BIT_DIR], !s.ctrl[HTC_BIT_NARROW]};
		if (moved)
		begin
			next_s.count = s.ctrl[HTC_BIT_DIR] ? s.count + width : s.count - width;
		end
		if (ack_edge && s.drq && s.stage2.last)
		begin
			next_s.done = 1'b1;
		end
		// Control register write; the clear bit never stays stored.
		if (write_edge && s.stage2.addr == HTC_CTRL_ADDR)
		begin
			next_s.ctrl = s.stage2.wdata & ~(8'h01 << HTC_BIT_CLEAR);
			if (s.stage2.wdata[HTC_BIT_CLEAR])
			begin
				next_s.count = HTC_COUNT_RESET;
			end
			if (!s.stage2.wdata[HTC_BIT_ENABLE])
			begin
				next_s.done = 1'b0;
			end
		end
		// Host register reads; unmapped addresses read as zero.
		if (read_edge)
		begin
			if (s.stage2.addr == HTC_CTRL_ADDR)
			begin
				next_s.rdata = s.ctrl;
			end
			else if (s.stage2.addr == HTC_COUNT_ADDR)
			begin
				next_s.rdata = s.count;
			end
			else
			begin
				next_s.rdata = 8'h00;
			end
		end
		// Room is judged on the count and control byte that the next cycle holds.
		room_width = next_s.ctrl[HTC_BIT_NARROW] ? HTC_NARROW_BYTES : HTC_WIDE_BYTES;
		room = next_s.ctrl[HTC_BIT_DIR] ? (next_s.count <= DEPTH_BYTES - room_width)
			: (next_s.count >= room_width);
		// The next control byte is used so that a disabling write leaves no stray request.
		// mode selects request kind
		next_s.drq = next_s.ctrl[HTC_BIT_ENABLE] && next_s.ctrl[HTC_BIT_DMA] && !next_s.done && room && !moved;
		next_s.pio_ready = next_s.ctrl[HTC_BIT_ENABLE] && !next_s.ctrl[HTC_BIT_DMA] && room && !moved;
		next_s.quad_port = s.ctrl[HTC_BIT_QUAD];
		next_s.irq = s.ctrl[HTC_BIT_GATE] && (s.ctrl[HTC_BIT_SOFT] || event_irq);
	end

	// Register the whole state; synchronous reset loads constants only.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			s <= '0;
			s.ctrl <= HTC_CTRL_RESET;
			s.count <= HTC_COUNT_RESET;
		end
		else
		begin
			s <= next_s;
		end
	end

	// Outputs come straight from the state flops.
	assign host_rdata = s.rdata;
	assign dma_request = s.drq;
	assign pio_ready = s.pio_ready;
	assign quad_port = s.quad_port;
	assign irq = s.irq;
	assign host_side_done = s.done;
	assign buffer_byte_count = s.count;
	assign xfer = s.xfer;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// A control write seen at the second synchroniser stage.
	sequence s_ctrl_write;
		s.stage2.write && !s.prev.write && s.stage2.addr == HTC_CTRL_ADDR;
	endsequence

	// A DMA acknowledge edge while requesting.
	sequence s_dma_beat;
		s.stage2.ack && !s.prev.ack && s.drq;
	endsequence

	property p_write_applies;
		s_ctrl_write |=> s.ctrl == ($past(s.stage2.wdata) & 8'hFD);
	endproperty
	a_write_applies: assert property (p_write_applies) else $error("control write not applied");

	property p_count_clear;
		(s_ctrl_write and s.stage2.wdata[1]) |=> s.count == 8'h00 && !s.ctrl[1];
	endproperty
	a_count_clear: assert property (p_count_clear) else $error("count clear failed");

	property p_gate_masks;
		!s.ctrl[2] |=> !s.irq;
	endproperty
	a_gate_masks: assert property (p_gate_masks) else $error("irq while gate clear");

	property p_soft_irq;
		s.ctrl[2] && s.ctrl[0] |=> s.irq;
	endproperty
	a_soft_irq: assert property (p_soft_irq) else $error("soft irq not raised");

	property p_disable_clears_done;
		(s_ctrl_write and !s.stage2.wdata[7]) |=> !s.done ##1 !s.drq;
	endproperty
	a_disable_clears_done: assert property (p_disable_clears_done) else $error("done not cleared");

	property p_last_sets_done;
		(s_dma_beat and s.stage2.last) |=> s.done;
	endproperty
	a_last_sets_done: assert property (p_last_sets_done) else $error("done not set");

	property p_enable_gates;
		!s.ctrl[7] |-> !s.drq && !s.pio_ready;
	endproperty
	a_enable_gates: assert property (p_enable_gates) else $error("movement while disabled");

	property p_mode_select;
		(s.drq |-> s.ctrl[5]) and (s.pio_ready |-> !s.ctrl[5]);
	endproperty
	a_mode_select: assert property (p_mode_select) else $error("wrong transfer mode");

	property p_width_dir;
		s_dma_beat |=> s.xfer.pulse && s.xfer.wide == !$past(s.ctrl[6]) && s.xfer.to_buffer == $past(s.ctrl[3]);
	endproperty
	a_width_dir: assert property (p_width_dir) else $error("transfer width or direction wrong");

	property p_alias_port;
		(s.stage2.write && !s.prev.write && s.pio_ready && s.ctrl[4]
			&& s.stage2.addr == HTC_DATA_ALIAS_ADDR) |=> s.xfer.pulse;
	endproperty
	a_alias_port: assert property (p_alias_port) else $error("alias address not served");

	property p_quad_flag;
		1'b1 |=> s.quad_port == $past(s.ctrl[4]);
	endproperty
	a_quad_flag: assert property (p_quad_flag) else $error("quad port flag wrong");
endmodule : htc_host_transfer_control

// file: bench/htc_dma_partner.sv
/*
  Host DMA controller model that answers the block's DMA requests.
  Assumes the block's single clock and its synchronous reset.
*/
`timescale 1ns/1ps
module htc_dma_partner
	import htc_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Bench controls: terminal count beat and slow answer.
	input wire logic last_beat,
	input wire logic slow,
	// DMA pins.
	input wire logic dma_request,
	output logic dma_ack,
	output logic dma_last
);
	// Cycles left in the current beat.
	logic [3:0] phase;

	// Ack stands three cycles, then rests at least seven.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			phase <= 4'h0;
			dma_ack <= 1'b0;
			dma_last <= 1'b0;
		end
		else if (phase != 4'h0)
		begin
			phase <= phase - 4'h1;
			dma_ack <= (phase > 4'h7) && (phase < 4'hB);
			dma_last <= (phase > 4'h7) && (phase < 4'hB) && last_beat;
		end
		else if (dma_request)
		begin
			// A slow answer waits six cycles before the ack.
			phase <= slow ? 4'hF : 4'h9;
			dma_ack <= !slow;
			dma_last <= !slow && last_beat;
		end
	end
endmodule : htc_dma_partner

// file: bench/htc_host_transfer_control_tb.sv
/*
  Self-checking bench for the host transfer control block.
  Assumes the DMA partner model stands on the far side of the DMA pins.
*/
`timescale 1ns/1ps
module htc_host_transfer_control_tb
	import htc_pkg::*;
;
	logic clock = 1'b0, reset = 1'b1, host_write = 1'b0, host_read = 1'b0, event_irq = 1'b0, slow = 1'b0;
	logic [9:0] host_addr = 10'h000;
	logic [7:0] host_wdata = 8'h00, cfg = 8'h00, host_rdata, buffer_byte_count;
	logic dma_ack, dma_last, dma_request, pio_ready, quad_port, irq, host_side_done;
	htc_xfer_s xfer;
	int miscompares = 0, check_count = 0, pulses = 0, n = 0, exp_cnt = 0;
	// The partner flags terminal count on the final beat.
	wire last_beat = (pulses == n - 1);

	always #50 clock = ~clock;

	htc_host_transfer_control u_dut (.clock(clock), .reset(reset), .host_write(host_write),
		.host_read(host_read), .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
		.dma_ack(dma_ack), .dma_last(dma_last), .dma_request(dma_request), .pio_ready(pio_ready),
		.quad_port(quad_port), .event_irq(event_irq), .irq(irq), .host_side_done(host_side_done),
		.buffer_byte_count(buffer_byte_count), .xfer(xfer));
	htc_dma_partner u_partner (.clock(clock), .reset(reset), .last_beat(last_beat), .slow(slow),
		.dma_request(dma_request), .dma_ack(dma_ack), .dma_last(dma_last));

	// Expected pin level from the control byte and other sources.
	function automatic logic exp_irq(input logic [7:0] c, input logic e);
		return c[HTC_BIT_GATE] & (c[HTC_BIT_SOFT] | e);
	endfunction : exp_irq

	// Bytes moved by one beat.
	function automatic int beat_bytes(input logic [7:0] c);
		return c[HTC_BIT_NARROW] ? 1 : 2;
	endfunction : beat_bytes

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// One host strobe: high three cycles, low three cycles.
	task automatic access(input logic wr, input logic [9:0] a, input logic [7:0] d);
		@(posedge clock);
		host_addr <= a;
		host_wdata <= d;
		host_write <= wr;
		host_read <= !wr;
		repeat (3) @(posedge clock);
		host_write <= 1'b0;
		host_read <= 1'b0;
		repeat (3) @(posedge clock);
	endtask : access

	task automatic wait_ready();
		for (int k = 0; k < 300 && pio_ready !== 1'b1; k++) @(posedge clock);
	endtask : wait_ready

	task close_out();
		$display("miscompares=%0d check_count=%0d", miscompares, check_count);
		if (miscompares == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	// Every counted transfer carries direction and width of the control byte.
	always @(posedge clock)
	begin
		if (!reset && xfer.pulse === 1'b1)
		begin
			pulses++;
			check({6'h00, xfer.to_buffer, xfer.wide}, {6'h00, cfg[3], !cfg[6]});
		end
	end

	// Watchdog against a hang.
	initial
	begin
		repeat (20000) @(posedge clock);
		miscompares++;
		close_out();
	end

	initial
	begin
		void'($urandom(13301));
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		access(1'b0, HTC_CTRL_ADDR, 8'h00);
		check(host_rdata, HTC_CTRL_RESET);
		access(1'b0, 10'h357, 8'h00);
		check(host_rdata, 8'h00);
		// Gate and soft request, corners then random; the clear bit never reads back.
		for (int i = 0; i < 10; i++)
		begin
			cfg = (i < 4) ? {5'h00, i[1], 1'b0, i[0]} : (8'($urandom) & 8'h05);
			event_irq <= 1'($urandom);
			access(1'b1, HTC_CTRL_ADDR, cfg | 8'h02);
			check({7'h00, irq}, {7'h00, exp_irq(cfg, event_irq)});
			access(1'b0, HTC_CTRL_ADDR, 8'h00);
			check(host_rdata, cfg);
		end
		// DMA: narrow and wide into the buffer, then wide back out.
		for (int j = 0; j < 3; j++)
		begin
			cfg = (j == 0) ? 8'hE8 : ((j == 1) ? 8'hA8 : 8'hA0);
			n = (j == 2) ? 1 : 1 + ($urandom % 4);
			pulses = 0;
			slow <= 1'($urandom);
			access(1'b1, HTC_CTRL_ADDR, cfg);
			for (int k = 0; k < 500 && host_side_done !== 1'b1; k++) @(posedge clock);
			repeat (20) @(posedge clock);
			check({7'h00, host_side_done}, 8'h01);
			check(pulses[7:0], n[7:0]);
			check({7'h00, dma_request}, 8'h00);
			exp_cnt = cfg[3] ? exp_cnt + n * beat_bytes(cfg) : exp_cnt - n * beat_bytes(cfg);
			access(1'b0, HTC_COUNT_ADDR, 8'h00);
			check(host_rdata, exp_cnt[7:0]);
			check(buffer_byte_count, exp_cnt[7:0]);
			access(1'b1, HTC_CTRL_ADDR, cfg & 8'h7F);
			check({6'h00, host_side_done, dma_request}, 8'h00);
		end
		access(1'b1, HTC_CTRL_ADDR, 8'h02);
		access(1'b0, HTC_COUNT_ADDR, 8'h00);
		check(host_rdata, 8'h00);
		check(buffer_byte_count, 8'h00);
		// Quad port without enable moves nothing; narrow select stays clear in quad mode.
		// narrow kept clear
		cfg = 8'h18;
		access(1'b1, HTC_CTRL_ADDR, cfg);
		check({7'h00, pio_ready}, 8'h00);
		cfg = 8'h98;
		access(1'b1, HTC_CTRL_ADDR, cfg);
		check({7'h00, quad_port}, 8'h01);
		for (int k = 0; k < 2; k++)
		begin
			wait_ready();
			access(1'b1, (k == 0) ? HTC_DATA_ALIAS_ADDR : HTC_DATA_ADDR, 8'($urandom));
		end
		access(1'b0, HTC_COUNT_ADDR, 8'h00);
		check(host_rdata, 8'h04);
		// Without the quad bit the alias address is no data port.
		cfg = 8'h88;
		access(1'b1, HTC_CTRL_ADDR, cfg);
		wait_ready();
		access(1'b1, HTC_DATA_ALIAS_ADDR, 8'($urandom));
		access(1'b0, HTC_COUNT_ADDR, 8'h00);
		check({host_rdata[6:0], quad_port}, 8'h08);
		close_out();
	end
endmodule : htc_host_transfer_control_tb
